// [rtl/bsq_pkg.sv]
/*
  Package for the block status and queue pointer bookkeeping.
  Holds register offsets, field positions, reset values and mode codes.
  Assumes one device clock and a synchronous active-high reset.
*/
package bsq_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [15:0] BSQ_QPTR_OFFSET     = 16'h001f;
  localparam logic [15:0] BSQ_ROLL_CLR_OFFSET = 16'h0000;
  localparam logic [15:0] BSQ_QPTR_RESET      = 16'h0000;
  localparam logic [15:0] BSQ_BSW_RESET       = 16'h0000;

  // ---------------------------------------------------------------
  // Queue pointer fields
  // ---------------------------------------------------------------
  localparam int BSQ_QPTR_BASE_LSB            = 6;
  localparam int BSQ_QPTR_NEXT_MSB            = 5;

  // ---------------------------------------------------------------
  // Block status word fields and the rollover status bit
  // ---------------------------------------------------------------
  localparam int BSQ_BSW_FINISHED             = 15;
  localparam int BSQ_BSW_IN_PROGRESS          = 14;
  localparam int BSQ_BSW_BUS_SELECT           = 13;
  localparam int BSQ_BSW_ERROR_FLAG           = 12;
  localparam int BSQ_BSW_UNEXP_STATUS         = 11;
  localparam int BSQ_BSW_ERR_HI               = 10;
  localparam int BSQ_BSW_ERR_LO               = 8;
  localparam int BSQ_ROLLOVER_BIT             = 12;

  // Operating modes
  typedef enum logic [1:0] {
    BSQ_MODE_BUS_CONTROLLER,
    BSQ_MODE_REMOTE_TERMINAL,
    BSQ_MODE_MONITOR_TERMINAL
  } bsq_mode_t;

endpackage : bsq_pkg

// [rtl/bsq_queue_ptr.sv]
/*
  Queue pointer register: base field plus six-bit next-location field.
  Assumes host writes and device store strobes arrive on the same clock.
*/
`timescale 1ns/10ps
module bsq_queue_ptr
  import bsq_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  input  wire logic        wr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        store_i,
  output logic      [15:0] qptr_o,
  output logic             wrap_o
);

  // ---------------------------------------------------------------
  // Next pointer
  // ---------------------------------------------------------------
  wire logic [5:0]  next_loc = qptr_o[BSQ_QPTR_NEXT_MSB:0] + 6'h01;
  wire logic [15:0] next_qptr = wr_i ? wdata_i :
                                store_i ? {qptr_o[15:BSQ_QPTR_BASE_LSB], next_loc} : qptr_o;

  // Host write wins over a same-cycle store; software owns the pointer
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      qptr_o <= BSQ_QPTR_RESET;
      wrap_o <= 1'b0;
    end else begin
      qptr_o <= next_qptr;
      wrap_o <= !wr_i && store_i && (qptr_o[BSQ_QPTR_NEXT_MSB:0] == 6'h3f);
    end
  end

  a_base_kept: assert property (@(posedge clk_i) disable iff (srst_i)
    (store_i && !wr_i) |=> qptr_o[15:6] == $past(qptr_o[15:6]))
    else $error("queue base changed on store");
  a_wrap_pulse: assert property (@(posedge clk_i) disable iff (srst_i)
    wrap_o |-> qptr_o[5:0] == 6'h00)
    else $error("wrap without zero location");

endmodule : bsq_queue_ptr

// [rtl/bsq_status_word.sv]
/*
  Builds the block status word of one bus controller message.
  Assumes start and end strobes come from the message sequencer.
*/
`timescale 1ns/10ps
module bsq_status_word
  import bsq_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  input  wire logic        start_i,
  input  wire logic        end_i,
  input  wire logic        bus_b_i,
  input  wire logic [2:0]  err_i,
  input  wire logic        hs_fail_i,
  input  wire logic        transparent_i,
  input  wire logic [10:0] rt_status_i,
  input  wire logic [10:0] expected_i,
  output logic      [15:0] word_o
);

  // ---------------------------------------------------------------
  // Field decode
  // ---------------------------------------------------------------
  // Mask bits of the control word are deliberately not an input here
  wire logic unexp = |(rt_status_i ^ expected_i);
  wire logic eflag = (|err_i) || (transparent_i && hs_fail_i);
  wire logic [2:0] errs = err_i;
  wire logic [15:0] done_word = {1'b1, 1'b0, bus_b_i, eflag, unexp, errs, 8'h00};
  wire logic [15:0] start_word = {1'b0, 1'b1, bus_b_i, 13'h0000};

  // Holds the word most recently produced
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      word_o <= BSQ_BSW_RESET;
    end else if (end_i) begin
      word_o <= done_word;
    end else if (start_i) begin
      word_o <= start_word;
    end
  end

  a_end_sets: assert property (@(posedge clk_i) disable iff (srst_i)
    end_i |=> word_o[15] && !word_o[14])
    else $error("finished flag missing");
  a_err_flag: assert property (@(posedge clk_i) disable iff (srst_i)
    (end_i && |err_i) |=> word_o[12])
    else $error("error flag missing");

endmodule : bsq_status_word

// [rtl/bsq_top.sv]
/*
  Queue pointer register and bus controller block status word writer.
  Assumes a simple synchronous host port and a shared RAM write port.
*/
// Summary of operation
// - Pointer serves queue chosen by mode
// - Base bits 15-6, next 5-0, reset zero
// - Wrap sets queue rollover bit twelve
// - Status word written to RAM at end
// - Host may read and write status word
// - Finished bit set on every message end
// - In-progress set at start, cleared at end
// - Bus select one for second bus
// - Error flag when bits 10-8 set
// - Transparent handshake failure: flag only
// - Unexpected status bit on mismatch
// - Control word masks ignored for status
`timescale 1ns/10ps
module bsq_top
  import bsq_pkg::*;
(
  input  wire logic        REF_CLK_I,
  input  wire logic        SRST_I,
  input  wire logic [1:0]  MODE_I,
  input  wire logic        HOST_WR_I,
  input  wire logic        HOST_RD_I,
  input  wire logic [15:0] HOST_ADDR_I,
  input  wire logic [15:0] HOST_WDATA_I,
  output logic      [15:0] HOST_RDATA_O,
  input  wire logic        QUEUE_STORE_I,
  input  wire logic        MSG_START_I,
  input  wire logic        MSG_END_I,
  input  wire logic [15:0] MSG_BLOCK_ADDR_I,
  input  wire logic        BUS_B_I,
  input  wire logic [2:0]  ERR_I,
  input  wire logic        HS_FAIL_I,
  input  wire logic        TRANSPARENT_I,
  input  wire logic [10:0] RT_STATUS_I,
  input  wire logic [10:0] EXPECTED_STATUS_I,
  output logic             RAM_WR_O,
  output logic      [15:0] RAM_ADDR_O,
  output logic      [15:0] RAM_WDATA_O,
  output logic      [15:0] ROLLOVER_STATUS_O,
  output logic      [15:0] QUEUE_PTR_O
);

  // ---------------------------------------------------------------
  // Host decode
  // ---------------------------------------------------------------
  // Address compare shared by the pointer port and the rollover clear
  function automatic logic addr_hit(input logic [15:0] addr, input logic [15:0] offset);
    return addr == offset;
  endfunction : addr_hit

  wire logic        qptr_hit = addr_hit(HOST_ADDR_I, BSQ_QPTR_OFFSET);
  wire logic        qptr_wr  = HOST_WR_I && qptr_hit;
  wire logic [15:0] qptr;
  wire logic        wrap;
  wire logic [15:0] word;
  logic             end_d;
  logic             start_d;
  logic [15:0]      blk_addr;

  bsq_queue_ptr u_qptr (
    .clk_i   (REF_CLK_I),
    .srst_i  (SRST_I),
    .wr_i    (qptr_wr),
    .wdata_i (HOST_WDATA_I),
    .store_i (QUEUE_STORE_I),
    .qptr_o  (qptr),
    .wrap_o  (wrap)
  );

  bsq_status_word u_bsw (
    .clk_i         (REF_CLK_I),
    .srst_i        (SRST_I),
    .start_i       (MSG_START_I),
    .end_i         (MSG_END_I),
    .bus_b_i       (BUS_B_I),
    .err_i         (ERR_I),
    .hs_fail_i     (HS_FAIL_I),
    .transparent_i (TRANSPARENT_I),
    .rt_status_i   (RT_STATUS_I),
    .expected_i    (EXPECTED_STATUS_I),
    .word_o        (word)
  );

  // Queue identity follows mode; same flop, different meaning
  wire logic bc_mode = MODE_I == BSQ_MODE_BUS_CONTROLLER;

  // Rollover is sticky; a host write to the clear address empties it
  wire logic        roll_clr  = HOST_WR_I && addr_hit(HOST_ADDR_I, BSQ_ROLL_CLR_OFFSET);
  wire logic [15:0] roll_set  = wrap ? (16'h0001 << BSQ_ROLLOVER_BIT) : 16'h0000;
  wire logic [15:0] next_roll = roll_clr ? 16'h0000 : ROLLOVER_STATUS_O;

  // ---------------------------------------------------------------
  // Output registers
  // ---------------------------------------------------------------
  // Host read data: only the pointer answers, every other address reads zero
  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      HOST_RDATA_O <= 16'h0000;
    end else begin
      HOST_RDATA_O <= (HOST_RD_I && qptr_hit) ? qptr : 16'h0000;
    end
  end

  // Rollover flag: the set is OR-ed after the clear, so an event is never lost
  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      ROLLOVER_STATUS_O <= 16'h0000;
    end else begin
      ROLLOVER_STATUS_O <= next_roll | roll_set;
    end
  end

  // Pointer mirror, one cycle behind the register itself
  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      QUEUE_PTR_O <= BSQ_QPTR_RESET;
    end else begin
      QUEUE_PTR_O <= qptr;
    end
  end

  // Strobe delays line the RAM write up with the word they produced
  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      end_d   <= 1'b0;
      start_d <= 1'b0;
    end else begin
      end_d   <= MSG_END_I;
      start_d <= MSG_START_I;
    end
  end

  // Block address caught at start, so a later change cannot move the write
  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      blk_addr <= 16'h0000;
    end else if (MSG_START_I) begin
      blk_addr <= MSG_BLOCK_ADDR_I;
    end
  end

  // Shared RAM port: one write after start, one after end
  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      RAM_WR_O    <= 1'b0;
      RAM_ADDR_O  <= 16'h0000;
      RAM_WDATA_O <= BSQ_BSW_RESET;
    end else begin
      RAM_WR_O    <= end_d || start_d;
      RAM_ADDR_O  <= blk_addr;
      RAM_WDATA_O <= word;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------

  a_ram_after_end: assert property (@(posedge REF_CLK_I) disable iff (SRST_I)
    MSG_END_I |=> ##1 RAM_WR_O && RAM_WDATA_O[15])
    else $error("status word not written after end");
  a_bus_select: assert property (@(posedge REF_CLK_I) disable iff (SRST_I)
    (MSG_END_I && BUS_B_I) |=> ##1 RAM_WDATA_O[13])
    else $error("bus select wrong");
  a_unexp_set: assert property (@(posedge REF_CLK_I) disable iff (SRST_I)
    (MSG_END_I && RT_STATUS_I != EXPECTED_STATUS_I) |=> ##1 RAM_WDATA_O[11])
    else $error("unexpected status not flagged");
  a_hs_fail: assert property (@(posedge REF_CLK_I) disable iff (SRST_I)
    (MSG_END_I && TRANSPARENT_I && HS_FAIL_I && ERR_I == 3'h0)
      |=> ##1 RAM_WDATA_O[12] && RAM_WDATA_O[10:8] == 3'h0)
    else $error("handshake failure coding wrong");
  a_roll_sticky: assert property (@(posedge REF_CLK_I) disable iff (SRST_I)
    wrap |=> ROLLOVER_STATUS_O[12])
    else $error("rollover not recorded");
  a_mode_note: assert property (@(posedge REF_CLK_I) disable iff (SRST_I)
    bc_mode |-> QUEUE_PTR_O == $past(qptr))
    else $error("pointer not mirrored");

  // Reads of anything but the pointer return zero
  // A stale pointer here would look like a valid queue entry
  a_rdata_miss: assert property (@(posedge REF_CLK_I) disable iff (SRST_I)
    !(HOST_RD_I && qptr_hit) |=> HOST_RDATA_O == 16'h0000)
    else $error("read data not zero");

  // A pointer read returns the register as it stood when asked
  // Same-cycle stores land afterwards and are seen by the next read
  a_rdata_qptr: assert property (@(posedge REF_CLK_I) disable iff (SRST_I)
    (HOST_RD_I && qptr_hit) |=> HOST_RDATA_O == $past(qptr))
    else $error("pointer read wrong");

  // A host write replaces both fields at once
  // The base field is plain read-write storage; a store also advances the next field
  a_qptr_write: assert property (@(posedge REF_CLK_I) disable iff (SRST_I)
    qptr_wr |=> qptr == $past(HOST_WDATA_I))
    else $error("pointer write lost");

  // Without a write or a store the pointer holds
  // Guards against a stray increment from a decode slip
  a_qptr_hold: assert property (@(posedge REF_CLK_I) disable iff (SRST_I)
    (!qptr_wr && !QUEUE_STORE_I) |=> qptr == $past(qptr))
    else $error("pointer moved by itself");

  // A store moves the next field on by one, modulo 64
  // The compare is six bits wide, so 63 plus one is zero
  a_store_step: assert property (@(posedge REF_CLK_I) disable iff (SRST_I)
    (QUEUE_STORE_I && !qptr_wr) |=> qptr[5:0] == $past(qptr[5:0]) + 6'h01)
    else $error("next location not advanced");

  // A wrap only follows a store from the last location
  // A false wrap would raise rollover with no lost entry
  a_wrap_cause: assert property (@(posedge REF_CLK_I) disable iff (SRST_I)
    wrap |-> $past(QUEUE_STORE_I) && $past(qptr[5:0]) == 6'h3f)
    else $error("wrap without cause");

  // Only the rollover position may ever be set
  // The other bits belong to events outside this block
  a_roll_only: assert property (@(posedge REF_CLK_I) disable iff (SRST_I)
    ROLLOVER_STATUS_O[15:13] == 3'h0 && ROLLOVER_STATUS_O[11:0] == 12'h000)
    else $error("stray rollover bit");

  // Without a wrap or a clear the flag keeps its value
  // Sticky so that software polling late still sees the event
  a_roll_hold: assert property (@(posedge REF_CLK_I) disable iff (SRST_I)
    (!wrap && !roll_clr) |=> ROLLOVER_STATUS_O == $past(ROLLOVER_STATUS_O))
    else $error("rollover changed by itself");

  // A clear alone empties the flag
  // Write to the clear address acknowledges the event
  a_roll_clear: assert property (@(posedge REF_CLK_I) disable iff (SRST_I)
    (roll_clr && !wrap) |=> ROLLOVER_STATUS_O == 16'h0000)
    else $error("rollover not cleared");

  // A wrap in the same cycle as a clear must still be seen
  // Losing it would hide an overwritten queue entry
  a_roll_wins: assert property (@(posedge REF_CLK_I) disable iff (SRST_I)
    (roll_clr && wrap) |=> ROLLOVER_STATUS_O[12])
    else $error("rollover lost to clear");

  // The start write shows a message in progress, not finished
  // An end in the next cycle still leaves this word in RAM first
  a_ram_start: assert property (@(posedge REF_CLK_I) disable iff (SRST_I)
    (MSG_START_I && !MSG_END_I) |=> ##1 RAM_WR_O && RAM_WDATA_O[14] && !RAM_WDATA_O[15])
    else $error("start word wrong");

  // The start write goes to the block named at start
  // Later changes of the address input must not move it
  a_ram_addr: assert property (@(posedge REF_CLK_I) disable iff (SRST_I)
    MSG_START_I |=> ##1 RAM_ADDR_O == $past(MSG_BLOCK_ADDR_I, 2))
    else $error("block address wrong");

  // No strobe, no RAM write two cycles on
  // A spurious write would overwrite a finished status word
  a_ram_quiet: assert property (@(posedge REF_CLK_I) disable iff (SRST_I)
    (!MSG_START_I && !MSG_END_I) |=> ##1 !RAM_WR_O)
    else $error("spurious RAM write");

  // The first bus reads back as zero in the finished word
  // Paired with the second-bus check, both polarities are covered
  a_bus_a: assert property (@(posedge REF_CLK_I) disable iff (SRST_I)
    (MSG_END_I && !BUS_B_I) |=> ##1 !RAM_WDATA_O[13])
    else $error("bus select set for first bus");

  // The start word carries the bus as well
  // Software may look at an unfinished block
  a_start_bus: assert property (@(posedge REF_CLK_I) disable iff (SRST_I)
    (MSG_START_I && !MSG_END_I) |=> ##1 RAM_WDATA_O[13] == $past(BUS_B_I, 2))
    else $error("bus select wrong at start");

  // Error bits land in positions 10 to 8 unchanged
  // They tell which error the flag stands for
  a_err_bits: assert property (@(posedge REF_CLK_I) disable iff (SRST_I)
    MSG_END_I |=> ##1 RAM_WDATA_O[10:8] == $past(ERR_I, 2))
    else $error("error bits wrong");

  // No error and no handshake failure: the flag stays clear
  // A set flag with zero error bits means handshake failure only
  a_flag_clear: assert property (@(posedge REF_CLK_I) disable iff (SRST_I)
    (MSG_END_I && ERR_I == 3'h0 && !(TRANSPARENT_I && HS_FAIL_I))
      |=> ##1 !RAM_WDATA_O[12])
    else $error("error flag set without cause");

  // Status as expected: the unexpected-status bit stays clear
  // No control word mask takes part in this decision
  a_unexp_clear: assert property (@(posedge REF_CLK_I) disable iff (SRST_I)
    (MSG_END_I && RT_STATUS_I == EXPECTED_STATUS_I) |=> ##1 !RAM_WDATA_O[11])
    else $error("unexpected status set wrongly");

  // Fields outside this block are written as zero
  // Their owners fill them in by their own writes
  a_low_byte: assert property (@(posedge REF_CLK_I) disable iff (SRST_I)
    RAM_WR_O |-> RAM_WDATA_O[7:0] == 8'h00)
    else $error("low byte not zero");

endmodule : bsq_top

// [dv/bsq_ram_model.sv]
/*
  Shared RAM model: keeps the last word the device writes, and where.
  Assumes one-cycle write strobes on the device clock.
*/
`timescale 1ns/10ps
module bsq_ram_model (
  input  wire logic        clk_i,
  input  wire logic        wr_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        host_wr_i,
  input  wire logic [15:0] host_wdata_i,
  output logic      [15:0] word_o,
  output logic      [15:0] addr_o,
  output int               writes_o
);
  // Plain storage, so the host side can overwrite it in any cycle without a device write
  initial writes_o = 0;
  always @(posedge clk_i) begin
    if (wr_i) begin
      word_o   <= wdata_i;
      addr_o   <= addr_i;
      writes_o <= writes_o + 1;
    end else if (host_wr_i) begin
      word_o   <= host_wdata_i;
    end
  end
endmodule : bsq_ram_model

// [dv/tb_bsq_top.sv]
/*
  Testbench for bsq_top: host register tasks and message sequences.
  Assumes the shared RAM model bsq_ram_model.
*/
`timescale 1ns/10ps
module tb_bsq_top;
  import bsq_pkg::*;
  logic clk = 0, srst = 1, wr = 0, rd = 0, store = 0, start = 0, stop = 0;
  logic bus_b = 0, hs = 0, transp = 0, ram_wr;
  logic [1:0] mode = 0;
  logic [2:0] err = 0;
  logic [10:0] rt = 0, exp_st = 0;
  logic [15:0] addr = 0, wdata = 0, blk = 16'h0120, rdata, ram_addr, ram_wdata, roll, word, waddr;
  logic [15:0] hdat = 0, qp;
  logic hwr = 0;
  int num_errors = 0, cmp_count = 0, cycles = 0, writes;
  always #2 clk = ~clk;
  bsq_top bsq_top_inst (.REF_CLK_I(clk), .SRST_I(srst), .MODE_I(mode), .HOST_WR_I(wr),
    .HOST_RD_I(rd), .HOST_ADDR_I(addr), .HOST_WDATA_I(wdata), .HOST_RDATA_O(rdata),
    .QUEUE_STORE_I(store), .MSG_START_I(start), .MSG_END_I(stop), .MSG_BLOCK_ADDR_I(blk),
    .BUS_B_I(bus_b), .ERR_I(err), .HS_FAIL_I(hs), .TRANSPARENT_I(transp), .RT_STATUS_I(rt),
    .EXPECTED_STATUS_I(exp_st), .RAM_WR_O(ram_wr), .RAM_ADDR_O(ram_addr),
    .RAM_WDATA_O(ram_wdata), .ROLLOVER_STATUS_O(roll), .QUEUE_PTR_O(qp));
  bsq_ram_model bsq_ram_model_inst (.clk_i(clk), .wr_i(ram_wr), .addr_i(ram_addr),
    .host_wr_i(hwr), .host_wdata_i(hdat),
    .wdata_i(ram_wdata), .word_o(word), .addr_o(waddr), .writes_o(writes));

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude

  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    cmp_count++;
    if (seen !== want) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen %h want %h", $time, seen, want);
    end
  endtask : check

  task automatic host_wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : host_wr

  // Read data is registered, so it is looked at just after the taking edge
  task automatic host_rd(input logic [15:0] a, input logic [15:0] want);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 check(rdata, want);
  endtask : host_rd

  task automatic pulse_store();
    @(posedge clk);
    store <= 1'b1;
    @(posedge clk);
    store <= 1'b0;
  endtask : pulse_store

  // Bounded wait for the RAM model to take one more write
  task automatic wait_ram(input int n);
    for (int i = 0; i < 10 && writes == n; i++) @(posedge clk);
    #1;
  endtask : wait_ram

  // One message: start, check the in-progress write, end, check the final top byte
  task automatic msg(input logic b, input logic [2:0] e, input logic h, input logic t,
                     input logic [10:0] r, input logic [10:0] x, input logic [7:0] want);
    int n;
    @(posedge clk);
    n = writes;
    bus_b <= b;
    err <= e;
    hs <= h;
    transp <= t;
    rt <= r;
    exp_st <= x;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    wait_ram(n);
    check({15'h0, word[14]}, 16'h0001);
    check(waddr, blk);
    n = writes;
    @(posedge clk);
    stop <= 1'b1;
    @(posedge clk);
    stop <= 1'b0;
    wait_ram(n);
    check({word[15:8], 8'h00}, {want, 8'h00});
  endtask : msg

  // Hang guard: the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      num_errors++;
      conclude();
    end
  end

  initial begin
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    host_rd(16'h001f, 16'h0000);
    host_rd(16'h0010, 16'h0000);
    check(roll, 16'h0000);
    // Wrap from 63 to 0 in every mode; base must survive
    for (int m = 0; m < 3; m++) begin
      @(posedge clk);
      mode <= 2'(m);
      host_wr(16'h001f, 16'hab7e);
      host_rd(16'h001f, 16'hab7e);
      pulse_store();
      host_rd(16'h001f, 16'hab7f);
      pulse_store();
      host_rd(16'h001f, 16'hab40);
      check(roll & 16'h1000, 16'h1000);
      check(qp, 16'hab40);
      host_wr(16'h0000, 16'h0000);
      repeat (2) @(posedge clk);
      check(roll, 16'h0000);
    end
    $display("queue pointer test done");
    msg(1'b0, 3'b000, 1'b0, 1'b0, 11'h000, 11'h000, 8'h80);
    msg(1'b1, 3'b101, 1'b0, 1'b0, 11'h600, 11'h000, 8'hbd);
    msg(1'b0, 3'b000, 1'b1, 1'b1, 11'h000, 11'h000, 8'h90);
    msg(1'b0, 3'b010, 1'b0, 1'b0, 11'h010, 11'h010, 8'h92);
    msg(1'b1, 3'b000, 1'b0, 1'b0, 11'h000, 11'h010, 8'ha8);
    // Host overwrites the status word in RAM and reads it back
    @(posedge clk);
    hdat <= 16'h1234;
    hwr <= 1'b1;
    @(posedge clk);
    hwr <= 1'b0;
    #1 check(word, 16'h1234);
    $display("status word test done");
    conclude();
  end
endmodule : tb_bsq_top
